// ---- pqm_fwd_map.sv ----
// Purpose: decode the unknown unicast port map into destination ports
// Assumes: two external ports plus a broadcast choice
// Notes:   combinational; bit 0 of the map is ignored
`timescale 1ns/1ps
module pqm_fwd_map (
    input  wire logic       enable_i,
    input  wire logic [4:0] map_i,
    output logic            to_port1_o,
    output logic            to_port2_o,
    output logic            to_all_o
);
    wire logic [3:0] code = map_i[4:1];
    wire logic       bcast = enable_i && (code == 4'hF);
    assign to_all_o   = bcast;
    assign to_port1_o = bcast || (enable_i && (code == 4'h1 || code == 4'h3));
    assign to_port2_o = bcast || (enable_i && (code == 4'h2 || code == 4'h3));
endmodule

// ---- pqm_pkg.sv ----
// Purpose: shared constants for the priority queue mapping block
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   tag_priority_map_upper has no printed offset here; 0x81 follows the lower map
package pqm_pkg;
    localparam int          REG_AW              = 8;
    localparam int          REG_DW              = 8;
    localparam logic [7:0]  ADDR_TAG_MAP_UPPER  = 8'h81;
    localparam logic [7:0]  ADDR_QUEUE_SPLIT    = 8'h82;
    localparam logic [7:0]  ADDR_UNKNOWN_UC     = 8'h83;
    // tag map field positions (low bit of each 2-bit field)
    localparam int          POS_TAG_FOUR        = 0;
    localparam int          POS_TAG_FIVE        = 2;
    localparam int          POS_TAG_SIX         = 4;
    localparam int          POS_TAG_SEVEN       = 6;
    localparam logic [7:0]  RST_TAG_MAP_UPPER   = 8'hFA;
    // queue split register
    localparam int          POS_SPLIT_SEL       = 6;
    localparam logic [1:0]  RST_SPLIT_SEL       = 2'h2;
    localparam logic [7:0]  RST_QUEUE_SPLIT     = 8'h84;
    localparam logic [7:0]  MASK_QUEUE_SPLIT    = 8'hC0;
    // unknown unicast register
    localparam int          POS_UC_ENABLE       = 5;
    localparam int          POS_UC_MAP          = 0;
    localparam logic [7:0]  RST_UNKNOWN_UC      = 8'h00;
    localparam logic [7:0]  MASK_UNKNOWN_UC     = 8'h3F;
    localparam logic [1:0]  SPLIT_ONLY_TOP      = 2'h0;
    localparam logic [1:0]  SPLIT_HALF          = 2'h2;
    localparam logic [1:0]  SPLIT_ALL_BUT_ZERO  = 2'h3;
endpackage

// ---- pqm_top.sv ----
// Purpose: 802.1p tag to priority map, two-queue split, unknown unicast forward
// Assumes: tag inputs synchronous to clk_i; one-cycle classify latency
// Notes:   split selector 01 gives an undefined queue, treated as high for 1 and 2
// Function
// - tag six uses map bits 5-4, reset 3
// - tag five uses map bits 3-2, reset 2
// - tag four uses map bits 1-0, reset 2
// - tag seven uses map bits 7-6, reset 3
// - split selector bits 7-6 choose queue
// - result 0 low, result 3 high always
// - selector 00: only result 3 high
// - selector 10 default: results 2,3 high
// - selector 11: only result 0 low
// - bit 5 enables unknown unicast forwarding
// - port map bits 4-1 choose destinations, bit 0 ignored
`timescale 1ns/1ps
module pqm_top (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       frame_valid_i,
    input  wire logic [2:0] frame_tag_i,
    output logic            prio_valid_o,
    output logic      [1:0] prio_o,
    output logic            high_queue_o,
    output logic            uc_port1_o,
    output logic            uc_port2_o,
    output logic            uc_all_o
);
    logic [7:0] tag_map;
    logic [7:0] queue_split;
    logic [7:0] unknown_uc;

    function automatic logic [1:0] field2(input logic [7:0] r, input int pos);
        field2 = r[pos +: 2];
    endfunction

    // field2 reads two bits, so a field must start at or below bit 6 of the byte
    if (pqm_pkg::POS_TAG_SEVEN + 2 > pqm_pkg::REG_DW) begin : g_bad_tag_pos
        $error("tag map field does not fit the register");
    end
    if (pqm_pkg::POS_SPLIT_SEL + 2 > pqm_pkg::REG_DW) begin : g_bad_split_pos
        $error("split selector does not fit the register");
    end
    // the port map must sit wholly below the enable bit or the two would alias
    if (pqm_pkg::POS_UC_MAP + 5 > pqm_pkg::POS_UC_ENABLE) begin : g_bad_uc_pos
        $error("forward port map overlaps the enable bit");
    end
    if (pqm_pkg::POS_UC_ENABLE >= pqm_pkg::REG_DW) begin : g_bad_uc_enable
        $error("forward enable does not fit the register");
    end
    // ports are fixed at one byte of address and data
    if (pqm_pkg::REG_AW != 8 || pqm_pkg::REG_DW != 8) begin : g_bad_bus
        $error("register port must be 8-bit address and 8-bit data");
    end

    wire logic       wr_tag   = wr_i && (addr_i == pqm_pkg::ADDR_TAG_MAP_UPPER);
    wire logic       wr_split = wr_i && (addr_i == pqm_pkg::ADDR_QUEUE_SPLIT);
    wire logic       wr_uc    = wr_i && (addr_i == pqm_pkg::ADDR_UNKNOWN_UC);
    // reserved bits keep their reset pattern so reads return it
    wire logic [7:0] next_split = (wdata_i & pqm_pkg::MASK_QUEUE_SPLIT)
                                | (pqm_pkg::RST_QUEUE_SPLIT & ~pqm_pkg::MASK_QUEUE_SPLIT);
    wire logic [7:0] next_uc    = wdata_i & pqm_pkg::MASK_UNKNOWN_UC;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tag_map     <= pqm_pkg::RST_TAG_MAP_UPPER;
            queue_split <= pqm_pkg::RST_QUEUE_SPLIT;
            unknown_uc  <= pqm_pkg::RST_UNKNOWN_UC;
        end else begin
            if (wr_tag) begin
                tag_map <= wdata_i;
            end
            if (wr_split) begin
                queue_split <= next_split;
            end
            if (wr_uc) begin
                unknown_uc <= next_uc;
            end
        end
    end

    wire logic [7:0] next_rdata = (addr_i == pqm_pkg::ADDR_TAG_MAP_UPPER) ? tag_map :
                                  (addr_i == pqm_pkg::ADDR_QUEUE_SPLIT)   ? queue_split :
                                  (addr_i == pqm_pkg::ADDR_UNKNOWN_UC)    ? unknown_uc : 8'h00;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

    // tags 0-3 map elsewhere; here they pass their top two bits as a stand-in
    logic [1:0] next_prio;
    always_comb begin
        case (frame_tag_i)
            3'h4:    next_prio = field2(tag_map, pqm_pkg::POS_TAG_FOUR);
            3'h5:    next_prio = field2(tag_map, pqm_pkg::POS_TAG_FIVE);
            3'h6:    next_prio = field2(tag_map, pqm_pkg::POS_TAG_SIX);
            3'h7:    next_prio = field2(tag_map, pqm_pkg::POS_TAG_SEVEN);
            default: next_prio = frame_tag_i[2:1];
        endcase
    end

    wire logic [1:0] split_sel = field2(queue_split, pqm_pkg::POS_SPLIT_SEL);
    logic next_high;
    always_comb begin
        case (split_sel)
            pqm_pkg::SPLIT_ONLY_TOP:     next_high = (next_prio == 2'h3);
            pqm_pkg::SPLIT_HALF:         next_high = next_prio[1];
            pqm_pkg::SPLIT_ALL_BUT_ZERO: next_high = (next_prio != 2'h0);
            default:                     next_high = (next_prio != 2'h0);
        endcase
    end

    logic fwd_p1;
    logic fwd_p2;
    logic fwd_all;
    pqm_fwd_map u_fwd (
        .enable_i   (unknown_uc[pqm_pkg::POS_UC_ENABLE]),
        .map_i      (unknown_uc[pqm_pkg::POS_UC_MAP +: 5]),
        .to_port1_o (fwd_p1),
        .to_port2_o (fwd_p2),
        .to_all_o   (fwd_all)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio_valid_o <= 1'b0;
            prio_o       <= 2'h0;
            high_queue_o <= 1'b0;
            uc_port1_o   <= 1'b0;
            uc_port2_o   <= 1'b0;
            uc_all_o     <= 1'b0;
        end else begin
            prio_valid_o <= frame_valid_i;
            prio_o       <= next_prio;
            high_queue_o <= next_high;
            uc_port1_o   <= fwd_p1;
            uc_port2_o   <= fwd_p2;
            uc_all_o     <= fwd_all;
        end
    end

    property p_tag_six;
        @(posedge clk_i) disable iff (!arst_n_i)
        (frame_tag_i == 3'h6) |=> (prio_o == $past(tag_map[5:4]));
    endproperty
    a_tag_six: assert property (p_tag_six) else $error("tag six priority wrong");

    property p_tag_five;
        @(posedge clk_i) disable iff (!arst_n_i)
        (frame_tag_i == 3'h5) |=> (prio_o == $past(tag_map[3:2]));
    endproperty
    a_tag_five: assert property (p_tag_five) else $error("tag five priority wrong");

    property p_tag_four;
        @(posedge clk_i) disable iff (!arst_n_i)
        (frame_tag_i == 3'h4) |=> (prio_o == $past(tag_map[1:0]));
    endproperty
    a_tag_four: assert property (p_tag_four) else $error("tag four priority wrong");

    property p_tag_seven;
        @(posedge clk_i) disable iff (!arst_n_i)
        (frame_tag_i == 3'h7) |=> (prio_o == $past(tag_map[7:6]));
    endproperty
    a_tag_seven: assert property (p_tag_seven) else $error("tag seven priority wrong");

    property p_ends_fixed;
        @(posedge clk_i) disable iff (!arst_n_i)
        (prio_o == 2'h0 || prio_o == 2'h3) |-> (high_queue_o == prio_o[0]);
    endproperty
    a_ends_fixed: assert property (p_ends_fixed) else $error("result 0 or 3 in wrong queue");

    property p_sel00;
        @(posedge clk_i) disable iff (!arst_n_i)
        (split_sel == 2'h0) |=> (high_queue_o == (prio_o == 2'h3));
    endproperty
    a_sel00: assert property (p_sel00) else $error("selector 00 split wrong");

    property p_sel10;
        @(posedge clk_i) disable iff (!arst_n_i)
        (split_sel == 2'h2) |=> (high_queue_o == prio_o[1]);
    endproperty
    a_sel10: assert property (p_sel10) else $error("selector 10 split wrong");

    property p_sel11;
        @(posedge clk_i) disable iff (!arst_n_i)
        (split_sel == 2'h3) |=> (high_queue_o == (prio_o != 2'h0));
    endproperty
    a_sel11: assert property (p_sel11) else $error("selector 11 split wrong");

    property p_uc_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        !unknown_uc[5] |=> !(uc_port1_o || uc_port2_o || uc_all_o);
    endproperty
    a_uc_off: assert property (p_uc_off) else $error("forward while disabled");

    property p_uc_both;
        @(posedge clk_i) disable iff (!arst_n_i)
        (unknown_uc[5:1] == 5'h13) |=> (uc_port1_o && uc_port2_o && !uc_all_o);
    endproperty
    a_uc_both: assert property (p_uc_both) else $error("port 1 and 2 map wrong");

    property p_reserved;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_split |=> (queue_split[5:0] == 6'h04);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits changed");

    property p_reserved_uc;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_uc |=> (unknown_uc[7:6] == 2'h0);
    endproperty
    a_reserved_uc: assert property (p_reserved_uc) else $error("forward reserved bits changed");

    property p_read_split;
        @(posedge clk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == pqm_pkg::ADDR_QUEUE_SPLIT) |=> (rdata_o[5:0] == 6'h04);
    endproperty
    a_read_split: assert property (p_read_split) else $error("split reserved bits read wrong");

    // register side: a write lands on the next edge, nothing else moves a field
    property p_map_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_tag |=> (tag_map == $past(wdata_i));
    endproperty
    a_map_write: assert property (p_map_write) else $error("tag map write lost");

    property p_map_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !wr_tag |=> $stable(tag_map);
    endproperty
    a_map_hold: assert property (p_map_hold) else $error("tag map moved without write");

    property p_read_map;
        @(posedge clk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == pqm_pkg::ADDR_TAG_MAP_UPPER) |=> (rdata_o == $past(tag_map));
    endproperty
    a_read_map: assert property (p_read_map) else $error("tag map read wrong");

    property p_split_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_split |=> (split_sel == $past(wdata_i[7:6]));
    endproperty
    a_split_write: assert property (p_split_write) else $error("split selector write lost");

    property p_split_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !wr_split |=> $stable(queue_split);
    endproperty
    a_split_hold: assert property (p_split_hold) else $error("split register moved without write");

    property p_uc_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_uc |=> (unknown_uc[5:0] == $past(wdata_i[5:0]));
    endproperty
    a_uc_write: assert property (p_uc_write) else $error("forward control write lost");

    property p_valid_follows;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> (prio_valid_o == $past(frame_valid_i));
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("result valid out of step");

    // forwarding decode: port 1, port 2 and broadcast patterns with the enable set, then the all-zero filter map
    property p_uc_port1;
        @(posedge clk_i) disable iff (!arst_n_i)
        (unknown_uc[5:1] == 5'h11) |=> (uc_port1_o && !uc_port2_o && !uc_all_o);
    endproperty
    a_uc_port1: assert property (p_uc_port1) else $error("port 1 map wrong");

    property p_uc_port2;
        @(posedge clk_i) disable iff (!arst_n_i)
        (unknown_uc[5:1] == 5'h12) |=> (!uc_port1_o && uc_port2_o && !uc_all_o);
    endproperty
    a_uc_port2: assert property (p_uc_port2) else $error("port 2 map wrong");

    property p_uc_bcast;
        @(posedge clk_i) disable iff (!arst_n_i)
        (unknown_uc[5:1] == 5'h1F) |=> (uc_port1_o && uc_port2_o && uc_all_o);
    endproperty
    a_uc_bcast: assert property (p_uc_bcast) else $error("broadcast map wrong");

    property p_uc_filter;
        @(posedge clk_i) disable iff (!arst_n_i)
        (unknown_uc[4:0] == 5'h00) |=> !(uc_port1_o || uc_port2_o || uc_all_o);
    endproperty
    a_uc_filter: assert property (p_uc_filter) else $error("filter map still forwards");

    c_high: cover property (@(posedge clk_i) disable iff (!arst_n_i) frame_valid_i ##1 high_queue_o);
    c_sel00: cover property (@(posedge clk_i) disable iff (!arst_n_i) split_sel == 2'h0 ##1 prio_valid_o && !high_queue_o);
    c_port2: cover property (@(posedge clk_i) disable iff (!arst_n_i) uc_port2_o && !uc_port1_o);
    c_sel11: cover property (@(posedge clk_i) disable iff (!arst_n_i) split_sel == 2'h3 ##1 high_queue_o);
    c_bcast: cover property (@(posedge clk_i) disable iff (!arst_n_i) uc_all_o);
endmodule

// ---- test_priority_queue_mapping.sv ----
// Purpose: self-checking bench for the priority queue mapping block
// Assumes: rdata_o in the cycle after rd_i; classify outputs one cycle after the tag
// Notes:   broadcast expects every destination output high
`timescale 1ns/1ps
module test_priority_queue_mapping;
    logic       clk_i         = 1'b0;
    logic       arst_n_i      = 1'b0;
    logic [7:0] addr_i        = 8'h00;
    logic [7:0] wdata_i       = 8'h00;
    logic       wr_i          = 1'b0;
    logic       rd_i          = 1'b0;
    logic       frame_valid_i = 1'b0;
    logic [2:0] frame_tag_i   = 3'h0;
    logic [7:0] rdata_o;
    logic       prio_valid_o;
    logic [1:0] prio_o;
    logic       high_queue_o;
    logic       uc_port1_o;
    logic       uc_port2_o;
    logic       uc_all_o;
    int         fails         = 0;
    int         n_compared    = 0;
    int         cycles        = 0;

    always #20 clk_i = ~clk_i;

    pqm_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .frame_valid_i(frame_valid_i), .frame_tag_i(frame_tag_i),
        .prio_valid_o(prio_valid_o), .prio_o(prio_o), .high_queue_o(high_queue_o),
        .uc_port1_o(uc_port1_o), .uc_port2_o(uc_port2_o), .uc_all_o(uc_all_o));

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang would otherwise run forever; the whole run needs about 110 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk("rdata_o", rdata_o, exp);
    endtask

    task automatic classify(input logic [2:0] t, input logic [1:0] p, input logic h);
        @(posedge clk_i);
        frame_valid_i <= 1'b1;
        frame_tag_i   <= t;
        @(posedge clk_i);
        frame_valid_i <= 1'b0;
        #1 chk("prio_valid_o", prio_valid_o, 8'h01);
        chk("prio_o", prio_o, p);
        chk("high_queue_o", high_queue_o, h);
    endtask

    task automatic test_reset_values;
        reg_rd(8'h81, 8'hFA);
        reg_rd(8'h82, 8'h84);
        reg_rd(8'h83, 8'h00);
        classify(3'h4, 2'h2, 1'b1);
        classify(3'h5, 2'h2, 1'b1);
        classify(3'h6, 2'h3, 1'b1);
        classify(3'h7, 2'h3, 1'b1);
        $display("test reset values done");
    endtask

    task automatic test_split;
        logic [1:0] sels [3] = '{2'h0, 2'h2, 2'h3}; // selector 01 never programmed
        logic [1:0] r;
        logic       h;
        reg_wr(8'h81, 8'h1B);
        reg_rd(8'h81, 8'h1B);
        foreach (sels[i]) begin
            reg_wr(8'h82, {sels[i], 6'h00});
            for (int t = 4; t < 8; t++) begin
                r = 2'(7 - t);
                h = (sels[i] == 2'h0) ? (r == 2'h3) : (sels[i] == 2'h2) ? (r >= 2'h2) : (r != 2'h0);
                classify(3'(t), r, h);
            end
        end
        $display("test split done");
    endtask

    task automatic test_reserved;
        reg_wr(8'h82, 8'h3F);
        reg_rd(8'h82, 8'h04);
        classify(3'h5, 2'h2, 1'b0);
        reg_wr(8'h82, 8'hFB);
        reg_rd(8'h82, 8'hC4);
        reg_wr(8'h83, 8'hFF);
        reg_rd(8'h83, 8'h3F);
        reg_wr(8'h90, 8'h55);
        reg_rd(8'h90, 8'h00);
        reg_rd(8'h81, 8'h1B);
        $display("test reserved done");
    endtask

    task automatic test_unknown_uc;
        logic [7:0] codes [6] = '{8'h20, 8'h22, 8'h25, 8'h26, 8'h3E, 8'h02};
        logic [2:0] outs  [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h0};
        foreach (codes[i]) begin
            reg_wr(8'h83, codes[i]);
            @(posedge clk_i);
            @(posedge clk_i);
            #1 chk("uc_all_o", uc_all_o, outs[i][2]);
            chk("uc_port1_o", uc_port1_o, outs[i][0]);
            chk("uc_port2_o", uc_port2_o, outs[i][1]);
        end
        $display("test unknown unicast done");
    endtask

    // written registers must fall back to reset values on a mid-run reset
    task automatic test_mid_reset;
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("high_queue_o", high_queue_o, 8'h00);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        reg_rd(8'h81, 8'hFA);
        reg_rd(8'h82, 8'h84);
        reg_rd(8'h83, 8'h00);
        $display("test mid-run reset done");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        test_reset_values();
        test_split();
        test_reserved();
        test_unknown_uc();
        test_mid_reset();
        complete_run();
    end
endmodule
